// ===== common/ivfs_defs.vh
// constants for the input voltage fault supervisor
`ifndef IVFS_DEFS_VH
`define IVFS_DEFS_VH
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define IVFS_CMD_OV_LIMIT   8'h55
`define IVFS_CMD_OV_RESP    8'h56
`define IVFS_CMD_UV_LIMIT   8'h59
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define IVFS_RESP_HI        7
`define IVFS_RESP_LO        6
`define IVFS_RETRY_HI       5
`define IVFS_RETRY_LO       3
`define IVFS_DELAY_HI       2
`define IVFS_DELAY_LO       0
`define IVFS_RESP_IGNORE    2'h0
`define IVFS_RETRY_NONE     3'h0
`define IVFS_RETRY_FOREVER  3'h7
`define IVFS_LIN_EXP        5'h1d
`define IVFS_OV_LIMIT_RST   16'he9e0
`define IVFS_UV_LIMIT_RST   16'he940
`define IVFS_OV_RESP_RST    8'h80
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IVFS_CLK_MHZ        200
`define IVFS_UNIT_MS        200
`define IVFS_UNIT_CYC       (`IVFS_UNIT_MS * 1000 * `IVFS_CLK_MHZ)
`endif

// ===== design/ivfs_regs.v
// command register store for the supervisor settings
`timescale 1ns/1ps
`include "ivfs_defs.vh"
module ivfs_regs (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        wr_en,
    input  wire [7:0]  wr_cmd,
    input  wire [15:0] wr_data,
    input  wire        rd_en,
    input  wire [7:0]  rd_cmd,
    output reg  [15:0] rd_data,
    output reg         rd_hit,
    output reg  [15:0] ov_limit_q,
    output reg  [15:0] uv_limit_q,
    output reg  [7:0]  ov_resp_q
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ov_limit_q <= `IVFS_OV_LIMIT_RST;
            uv_limit_q <= `IVFS_UV_LIMIT_RST;
            ov_resp_q  <= `IVFS_OV_RESP_RST;
            rd_data    <= 16'h0000;
            rd_hit     <= 1'b0;
        end else begin
            if (wr_en) begin
                case (wr_cmd)
                    `IVFS_CMD_OV_LIMIT: ov_limit_q <= wr_data;
                    `IVFS_CMD_UV_LIMIT: uv_limit_q <= wr_data;
                    `IVFS_CMD_OV_RESP:  ov_resp_q  <= wr_data[7:0];
                    default: ;
                endcase
            end
            rd_hit <= 1'b0;
            if (rd_en) begin
                rd_hit <= 1'b1;
                case (rd_cmd)
                    `IVFS_CMD_OV_LIMIT: rd_data <= ov_limit_q;
                    `IVFS_CMD_UV_LIMIT: rd_data <= uv_limit_q;
                    `IVFS_CMD_OV_RESP:  rd_data <= {8'h00, ov_resp_q};
                    default: begin
                        rd_data <= 16'h0000;
                        rd_hit  <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // ivfs_regs

// ===== design/ivfs_top.v
// input voltage fault supervisor: limits, trip compare, retry sequencer
`timescale 1ns/1ps
`include "ivfs_defs.vh"
module ivfs_top #(
    parameter UNIT_CYC = `IVFS_UNIT_CYC
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        cmd_wr,
    input  wire [7:0]  cmd_code,
    input  wire [15:0] cmd_wdata,
    input  wire        cmd_rd,
    output wire [15:0] cmd_rdata,
    output wire        cmd_rvalid,
    input  wire        run_en,
    input  wire        fault_clear,
    input  wire        other_fault,
    input  wire [15:0] vin_mant,
    output reg         out_en_q,
    output reg         ov_flag_q,
    output reg         uv_flag_q,
    output reg         ov_latched_off_q,
    output reg         retry_start_q
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg  [1:0] rst_sync_q;
    wire       rst_n;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    wire [15:0] ov_limit;
    wire [15:0] uv_limit;
    wire [7:0]  ov_resp;
    ivfs_regs u_regs (
        .clk        (clk),
        .rst_n      (rst_n),
        .wr_en      (cmd_wr),
        .wr_cmd     (cmd_code),
        .wr_data    (cmd_wdata),
        .rd_en      (cmd_rd),
        .rd_cmd     (cmd_code),
        .rd_data    (cmd_rdata),
        .rd_hit     (cmd_rvalid),
        .ov_limit_q (ov_limit),
        .uv_limit_q (uv_limit),
        .ov_resp_q  (ov_resp)
    );

    // both limits and the reading share exponent -3, so mantissas compare
    wire [10:0] ov_lim_m = ov_limit[10:0];
    wire [10:0] uv_lim_m = uv_limit[10:0];
    wire [10:0] vin_m    = vin_mant[10:0];
    wire        ov_trip  = vin_m > ov_lim_m;
    wire        uv_trip  = vin_m < uv_lim_m;

    wire [1:0] resp  = ov_resp[`IVFS_RESP_HI:`IVFS_RESP_LO];
    wire [2:0] retry = ov_resp[`IVFS_RETRY_HI:`IVFS_RETRY_LO];
    wire [2:0] delay = ov_resp[`IVFS_DELAY_HI:`IVFS_DELAY_LO];

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    localparam ST_OFF  = 2'd0;
    localparam ST_RUN  = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_LOCK = 2'd3;

    reg [1:0]  state_q;
    reg [2:0]  tries_q;
    reg [31:0] unit_q;
    reg [2:0]  units_q;
    wire       unit_tick = (unit_q == UNIT_CYC - 1);
    wire       enabled   = (state_q == ST_RUN);
    // elapsed units since the attempt began, counting a tick due now
    wire [3:0] units_now = {1'b0, units_q} + {3'h0, unit_tick};
    // a run longer than the delay restarts as soon as the output is off
    wire       delay_done = (units_now >= {1'b0, delay});
    wire       restart    = (state_q == ST_WAIT) && run_en && !other_fault
                            && delay_done;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q          <= ST_OFF;
            tries_q          <= 3'd0;
            unit_q           <= 32'd0;
            units_q          <= 3'd0;
            out_en_q         <= 1'b0;
            ov_flag_q        <= 1'b0;
            uv_flag_q        <= 1'b0;
            ov_latched_off_q <= 1'b0;
            retry_start_q    <= 1'b0;
        end else begin
            retry_start_q <= 1'b0;
            // flags only follow the input while the output is enabled
            if (enabled) begin
                ov_flag_q <= ov_trip;
                uv_flag_q <= uv_trip;
            end
            if (fault_clear && !enabled) begin
                ov_flag_q <= 1'b0;
                uv_flag_q <= 1'b0;
            end
            // delay runs from each attempt start, through run and wait
            if (restart || state_q == ST_OFF || state_q == ST_LOCK) begin
                unit_q  <= 32'h0;
                units_q <= 3'h0;
            end else begin
                unit_q <= unit_tick ? 32'h0 : unit_q + 32'h1;
                if (unit_tick && units_q != 3'h7)
                    units_q <= units_q + 3'h1;
            end
            case (state_q)
                ST_OFF: begin
                    out_en_q <= 1'b0;
                    tries_q  <= 3'd0;
                    // start ramp even with OV present; trip comes after
                    if (run_en && !other_fault) begin
                        state_q  <= ST_RUN;
                        out_en_q <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!run_en || other_fault) begin
                        state_q  <= ST_OFF;
                        out_en_q <= 1'b0;
                    end else if (ov_trip && resp != `IVFS_RESP_IGNORE) begin
                        out_en_q <= 1'b0;
                        if (retry == `IVFS_RETRY_NONE) begin
                            state_q          <= ST_LOCK;
                            ov_latched_off_q <= 1'b1;
                        end else if (retry != `IVFS_RETRY_FOREVER &&
                                     tries_q >= retry) begin
                            state_q          <= ST_LOCK;
                            ov_latched_off_q <= 1'b1;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    out_en_q <= 1'b0;
                    if (!run_en || other_fault) begin
                        state_q <= ST_OFF;
                    end else if (delay_done) begin
                        state_q       <= ST_RUN;
                        out_en_q      <= 1'b1;
                        retry_start_q <= 1'b1;
                        if (tries_q != 3'd7)
                            tries_q <= tries_q + 3'd1;
                    end
                end
                ST_LOCK: begin
                    out_en_q <= 1'b0;
                    if (fault_clear) begin
                        state_q          <= ST_OFF;
                        ov_latched_off_q <= 1'b0;
                    end
                end
                default: state_q <= ST_OFF;
            endcase
        end
    end
endmodule // ivfs_top

// ===== testbench/ivfs_host.sv
// host command model that writes and reads the supervisor settings
`timescale 1ns/1ps
`include "ivfs_defs.vh"
module ivfs_host (
    input  wire        clk,
    output reg         cmd_wr,
    output reg         cmd_rd,
    output reg  [7:0]  cmd_code,
    output reg  [15:0] cmd_wdata,
    input  wire        cmd_rvalid,
    input  wire [15:0] cmd_rdata
);
    initial {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = 26'h0;
    // limits always leave with the fixed exponent in the top five bits
    task wr(input [7:0] code, input [15:0] data);
        @(negedge clk);
        cmd_code = code;
        cmd_wdata = (code == 8'h56) ? data : {`IVFS_LIN_EXP, data[10:0]};
        cmd_wr = 1'b1;
        @(negedge clk);
        cmd_wr = 1'b0;
    endtask
    task rd(input [7:0] code, output [15:0] d, output v);
        @(negedge clk);
        cmd_code = code;
        cmd_rd = 1'b1;
        @(negedge clk);
        cmd_rd = 1'b0;
        v = cmd_rvalid;
        d = cmd_rdata;
    endtask
endmodule // ivfs_host

// ===== testbench/ivfs_assertions.sv
// port checker for the input voltage fault supervisor
`timescale 1ns/1ps
`include "ivfs_defs.vh"
module ivfs_checker (
    input wire        clk,
    input wire        reset_n,
    input wire        cmd_wr,
    input wire [7:0]  cmd_code,
    input wire [15:0] cmd_wdata,
    input wire        run_en,
    input wire        fault_clear,
    input wire        other_fault,
    input wire [15:0] vin_mant,
    input wire        out_en_q,
    input wire        ov_flag_q,
    input wire        ov_latched_off_q,
    input wire        retry_start_q
);
    reg  [7:0]  resp_q;
    reg  [15:0] lim_q;
    // mantissa only: both sides carry the same exponent
    wire        hi = vin_mant[10:0] > lim_q[10:0];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resp_q <= `IVFS_OV_RESP_RST;
            lim_q  <= `IVFS_OV_LIMIT_RST;
        end else if (cmd_wr && cmd_code == 8'h56) begin
            resp_q <= cmd_wdata[7:0];
        end else if (cmd_wr && cmd_code == 8'h55) begin
            lim_q  <= cmd_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_standby_hold: assert property (
        !run_en [*3] ##0 !fault_clear |=> $stable(ov_flag_q))
        else $error("flag moved in standby");
    a_trip_off: assert property (
        out_en_q && run_en && hi && resp_q[7:6] != 2'h0 |=> !out_en_q)
        else $error("output kept on over limit");
    a_ignore_on: assert property (
        out_en_q && run_en && !other_fault && resp_q[7:6] == 2'h0
        |=> out_en_q) else $error("ignore response dropped output");
    a_flag_set: assert property (
        out_en_q && run_en && hi |=> ov_flag_q) else $error("no flag");
    a_equal_quiet: assert property (
        run_en && !ov_flag_q && !hi |=> !ov_flag_q)
        else $error("flag at or below limit");
    a_lock_off: assert property (
        ov_latched_off_q |-> !out_en_q) else $error("on while locked");
    a_lock_hold: assert property (
        ov_latched_off_q && !fault_clear |=> ov_latched_off_q)
        else $error("lock left without clear");
    a_other_off: assert property (
        other_fault |=> !out_en_q) else $error("on during other fault");
    c_lock: cover property (ov_latched_off_q);
    c_retry: cover property (retry_start_q);
    c_trip: cover property ($fell(out_en_q) && run_en);
endmodule // ivfs_checker
bind ivfs_top ivfs_checker u_chk (.clk(clk), .reset_n(reset_n),
    .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .run_en(run_en), .fault_clear(fault_clear), .other_fault(other_fault),
    .vin_mant(vin_mant), .out_en_q(out_en_q), .ov_flag_q(ov_flag_q),
    .ov_latched_off_q(ov_latched_off_q), .retry_start_q(retry_start_q));

// ===== testbench/tb_ivfs_top.sv
// self-checking bench for the input voltage fault supervisor
`timescale 1ns/1ps
`include "ivfs_defs.vh"
module tb_ivfs_top;
    reg         clk, reset_n, run_en, fault_clear, other_fault, rd_v;
    reg  [15:0] vin, rd_d;
    wire        wr, rd, rv, out_en, flag, uv, lock, rs;
    wire [7:0]  code;
    wire [15:0] wd, rdat;
    integer     n_mismatch = 0, tests_run = 0, cnt, gap, last, i, r;
    ivfs_top #(.UNIT_CYC(10)) uut (.clk(clk), .reset_n(reset_n),
        .cmd_wr(wr), .cmd_code(code), .cmd_wdata(wd), .cmd_rd(rd),
        .cmd_rdata(rdat), .cmd_rvalid(rv), .run_en(run_en),
        .fault_clear(fault_clear), .other_fault(other_fault),
        .vin_mant(vin), .out_en_q(out_en), .ov_flag_q(flag),
        .uv_flag_q(uv), .ov_latched_off_q(lock), .retry_start_q(rs));
    ivfs_host host (.clk(clk), .cmd_wr(wr), .cmd_rd(rd), .cmd_code(code),
        .cmd_wdata(wd), .cmd_rvalid(rv), .cmd_rdata(rdat));
    task check(input string what, input [15:0] seen, input [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task go(input [7:0] resp, input [15:0] v);
        host.wr(8'h56, {8'h00, resp});
        vin = v;
        run_en = 1'b1;
        cnt = 0;
        last = 0;
        gap = 0;
        for (i = 0; i < 400 && lock !== 1'b1; i = i + 1) begin
            @(negedge clk);
            if (rs === 1'b1) begin
                gap = i - last;
                last = i;
                cnt = cnt + 1;
            end
        end
    endtask
    task idle;
        run_en = 1'b0;
        vin = 16'h0100;
        fault_clear = 1'b1;
        repeat (4) @(negedge clk);
        fault_clear = 1'b0;
    endtask
    task t_regs;
        host.rd(8'h55, rd_d, rd_v);
        check("ov limit", rd_d, `IVFS_OV_LIMIT_RST);
        host.wr(8'h59, 16'h0190);
        host.rd(8'h59, rd_d, rd_v);
        check("uv limit", rd_d, 16'he990);
        host.rd(8'h57, rd_d, rd_v);
        check("unmapped", rd_v, 1'b0);
    endtask
    task t_standby;
        vin = 16'h0200;
        repeat (10) @(negedge clk);
        check("standby flag", flag, 1'b0);
        go(8'h80, 16'h0200);
        check("fast trip", i < 6 && lock === 1'b1, 1'b1);
        check("trip flag", flag, 1'b1);
        idle;
    endtask
    task t_codes;
        go(8'h00, 16'h0200);
        check("ignore", {out_en, lock}, 2'b10);
        idle;
        go(8'h00, 16'h0100);
        check("uv flag", {out_en, uv}, 2'b11);
        idle;
        go(8'h80, 16'h01e0);
        check("equal", {out_en, flag}, 2'b10);
        idle;
        for (r = 1; r < 4; r = r + 2) begin
            go({r[1:0], 6'h00}, 16'h0200);
            check("reserved", lock, 1'b1);
            idle;
        end
    endtask
    task t_retries;
        for (r = 0; r < 7; r = r + 1) begin
            go({2'h2, r[2:0], 1'b0, r[1:0]}, 16'h0200);
            check("attempts", cnt[15:0], r[15:0]);
            check("lock", {out_en, lock}, 2'b01);
            if (r > 1)
                check("spacing", gap / 10, r % 4);
            idle;
        end
    endtask
    task t_forever;
        go(8'hb9, 16'h0200);
        check("no lock", {lock, cnt > 8}, 2'b01);
        other_fault = 1'b1;
        repeat (2) @(negedge clk);
        check("forced off", out_en, 1'b0);
        other_fault = 1'b0;
        run_en = 1'b0;
        cnt = 0;
        repeat (40) @(negedge clk) cnt = cnt + rs;
        check("stopped", cnt[15:0], 16'h0);
        idle;
    endtask
    task t_reset;
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        check("reset out", {out_en, lock, flag, uv}, 4'h0);
        host.rd(8'h56, rd_d, rd_v);
        check("reset resp", rd_d, `IVFS_OV_RESP_RST);
        host.rd(8'h59, rd_d, rd_v);
        check("reset uv", rd_d, `IVFS_UV_LIMIT_RST);
    endtask
    task report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
    initial begin
        {reset_n, run_en, fault_clear, other_fault} = 4'h0;
        vin = 16'h0100;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        t_regs;
        t_standby;
        t_codes;
        t_retries;
        t_forever;
        t_reset;
        report_and_stop;
    end
endmodule // tb_ivfs_top
